// ---- rtl/crf_pkg.sv ----
// Package: register map, status word layout and operation codes for the core registers
package crf_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int unsigned ADDR_W   = 10;
  localparam int unsigned DATA_W   = 32;

  // ************************************************************
  // Register indices, byte address is four times the index
  // ************************************************************
  localparam logic [7:0] IDX_STACK_TOP = 8'h81;
  localparam logic [7:0] IDX_PTR_LOW   = 8'h82;
  localparam logic [7:0] IDX_PTR_HIGH  = 8'h83;
  localparam logic [7:0] IDX_AUX_ONE   = 8'hA1;
  localparam logic [7:0] IDX_STATUS    = 8'hD0;
  localparam logic [7:0] IDX_MAIN      = 8'hE0;
  localparam logic [7:0] IDX_SECOND    = 8'hF0;

  // ************************************************************
  // Values after reset
  // ************************************************************
  localparam logic [7:0]  RST_STACK_TOP = 8'h07;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_POINTER   = 16'h0000;

  // ************************************************************
  // Status word and auxiliary control bit positions
  // ************************************************************
  localparam int unsigned STAT_CARRY   = 7;
  localparam int unsigned STAT_HALF    = 6;
  localparam int unsigned STAT_USER0   = 5;
  localparam int unsigned STAT_BANK_HI = 4;
  localparam int unsigned STAT_BANK_LO = 3;
  localparam int unsigned STAT_RANGE   = 2;
  localparam int unsigned STAT_USER1   = 1;
  localparam int unsigned STAT_PARITY  = 0;
  localparam int unsigned AUX_PTR_SEL  = 0;

  // ************************************************************
  // Arithmetic constants
  // ************************************************************
  localparam logic [3:0] BCD_NINE   = 4'h9;
  localparam logic [7:0] DA_LOW_ADJ = 8'h06;
  localparam logic [7:0] DA_HI_ADJ  = 8'h60;
  localparam logic [7:0] ZERO_BYTE  = 8'h00;

  typedef enum logic [3:0] {
    OP_NONE  = 4'b0000,
    OP_ADD   = 4'b0001,
    OP_ADDC  = 4'b0010,
    OP_SUBB  = 4'b0011,
    OP_MUL   = 4'b0100,
    OP_DIV   = 4'b0101,
    OP_DA    = 4'b0110,
    OP_CJNE  = 4'b0111,
    OP_PUSH  = 4'b1000,
    OP_POP   = 4'b1001,
    OP_INCDP = 4'b1010
  } crf_op_t;

  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_STACK  = 3'b001,
    SEL_PLOW   = 3'b010,
    SEL_PHIGH  = 3'b011,
    SEL_STATUS = 3'b100,
    SEL_MAIN   = 3'b101,
    SEL_SECOND = 3'b110,
    SEL_AUX    = 3'b111
  } crf_sel_t;

endpackage

// ---- rtl/crf_alu.sv ----
// Flag and result logic for the arithmetic operations
`timescale 1ns/1ps
module crf_alu (
  input  crf_pkg::crf_op_t       opCode,
  input  wire logic [7:0] firstIn,
  input  wire logic [7:0] secondIn,
  input  wire logic       carryIn,
  input  wire logic       halfIn,
  output logic      [7:0] resA,
  output logic      [7:0] resB,
  output logic            wrA,
  output logic            wrB,
  output logic            carryOut,
  output logic            halfOut,
  output logic            rangeOut,
  output logic            updCarry,
  output logic            updHalf,
  output logic            updRange
);
  import crf_pkg::*;

  logic        cin;
  logic [8:0]  full;
  logic [4:0]  nib;
  logic [7:0]  low7;
  logic [15:0] prod;
  logic [8:0]  adj;

  always_comb begin
    cin      = (opCode == OP_ADD) ? 1'b0 : carryIn;
    full     = 9'h000;
    nib      = 5'h00;
    low7     = 8'h00;
    prod     = 16'h0000;
    adj      = {1'b0, firstIn};
    resA     = firstIn;
    resB     = secondIn;
    wrA      = 1'b0;
    wrB      = 1'b0;
    carryOut = carryIn;
    halfOut  = halfIn;
    rangeOut = 1'b0;
    updCarry = 1'b0;
    updHalf  = 1'b0;
    updRange = 1'b0;
    case (opCode)
      OP_ADD, OP_ADDC: begin
        full = {1'b0, firstIn} + {1'b0, secondIn} + {8'h00, cin};
        nib  = {1'b0, firstIn[3:0]} + {1'b0, secondIn[3:0]} + {4'h0, cin};
        low7 = {1'b0, firstIn[6:0]} + {1'b0, secondIn[6:0]} + {7'h00, cin};
        resA = full[7:0];
        wrA  = 1'b1;
        carryOut = full[8];
        halfOut  = nib[4];
        rangeOut = full[8] ^ low7[7];
        {updCarry, updHalf, updRange} = 3'b111;
      end
      OP_SUBB: begin
        full = {1'b0, firstIn} - {1'b0, secondIn} - {8'h00, cin};
        nib  = {1'b0, firstIn[3:0]} - {1'b0, secondIn[3:0]} - {4'h0, cin};
        low7 = {1'b0, firstIn[6:0]} - {1'b0, secondIn[6:0]} - {7'h00, cin};
        resA = full[7:0];
        wrA  = 1'b1;
        carryOut = full[8];
        halfOut  = nib[4];
        rangeOut = full[8] ^ low7[7];
        {updCarry, updHalf, updRange} = 3'b111;
      end
      OP_MUL: begin
        prod = {8'h00, firstIn} * {8'h00, secondIn};
        resA = prod[7:0];
        resB = prod[15:8];
        {wrA, wrB} = 2'b11;
        carryOut = 1'b0;
        rangeOut = |prod[15:8];
        {updCarry, updRange} = 2'b11;
      end
      OP_DIV: begin
        carryOut = 1'b0;
        {updCarry, updRange} = 2'b11;
        if (secondIn == ZERO_BYTE) begin
          // Results undefined: both bytes are simply left alone
          rangeOut = 1'b1;
        end else begin
          resA = firstIn / secondIn;
          resB = firstIn % secondIn;
          {wrA, wrB} = 2'b11;
        end
      end
      OP_DA: begin
        if ((firstIn[3:0] > BCD_NINE) || halfIn) begin
          adj = {1'b0, firstIn} + {1'b0, DA_LOW_ADJ};
        end
        if ((adj[7:4] > BCD_NINE) || adj[8] || carryIn) begin
          adj = {1'b0, adj[7:0]} + {1'b0, DA_HI_ADJ} + {adj[8], 8'h00};
        end
        resA     = adj[7:0];
        wrA      = 1'b1;
        carryOut = adj[8] | carryIn;
        updCarry = 1'b1;
      end
      OP_CJNE: begin
        carryOut = firstIn < secondIn;
        updCarry = 1'b1;
      end
      default: begin
        wrA = 1'b0;
      end
    endcase
  end

endmodule

// ---- rtl/crf_core_regs.sv ----
// Core special registers, status word flags and their register-bus slave
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
module crf_core_regs (
  input  wire logic                         sys_clk,
  input  wire logic                         arst_n,
  // APB slave
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [crf_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [crf_pkg::DATA_W-1:0]   pwdata,
  output logic      [crf_pkg::DATA_W-1:0]   prdata,
  output logic                              pready,
  output logic                              pslverr,
  // Datapath operation port
  input  wire logic                         opStart,
  input  crf_pkg::crf_op_t                  opCode,
  input  wire logic [7:0]                   opFirst,
  input  wire logic [7:0]                   opSecond,
  input  wire logic [7:0]                   pushData,
  output logic                              stackWrite,
  output logic                              stackRead,
  output logic      [7:0]                   stackAddr,
  output logic      [7:0]                   stackData,
  // Single-bit access port
  input  wire logic                         bitValid,
  input  wire logic                         bitWrite,
  input  wire logic [7:0]                   bitAddr,
  input  wire logic                         bitValue,
  output logic                              bitReadData,
  // Register views for the datapath
  output logic      [7:0]                   mainArith,
  output logic      [7:0]                   secondOperand,
  output logic      [15:0]                  activePointer,
  output logic                              pointerSelect,
  output logic      [7:0]                   bankBase,
  output logic                              parityFlag
);
  import crf_pkg::*;

  // ************************************************************
  // Storage
  // ************************************************************
  logic [7:0]  mainArith_r;
  logic [7:0]  second_r;
  logic [7:0]  stackTop_r;
  logic [15:0] pointer_r [2];
  logic [7:1]  status_r;
  logic        ptrSel_r;
  logic [31:0] prdata_r;
  logic        bitReadData_r;
  logic        stackWrite_r;
  logic        stackRead_r;
  logic [7:0]  stackAddr_r;
  logic [7:0]  stackData_r;

  // ************************************************************
  // Decode helpers
  // ************************************************************
  function automatic crf_sel_t regSel(input logic [7:0] idx);
    case (idx)
      IDX_STACK_TOP: regSel = SEL_STACK;
      IDX_PTR_LOW:   regSel = SEL_PLOW;
      IDX_PTR_HIGH:  regSel = SEL_PHIGH;
      IDX_STATUS:    regSel = SEL_STATUS;
      IDX_MAIN:      regSel = SEL_MAIN;
      IDX_SECOND:    regSel = SEL_SECOND;
      IDX_AUX_ONE:   regSel = SEL_AUX;
      default:       regSel = SEL_NONE;
    endcase
  endfunction

  // Bit-addressable registers sit on an eight-aligned index
  function automatic crf_sel_t bitSel(input logic [7:0] addr);
    case ({addr[7:3], 3'b000})
      IDX_STATUS: bitSel = SEL_STATUS;
      IDX_MAIN:   bitSel = SEL_MAIN;
      IDX_SECOND: bitSel = SEL_SECOND;
      default:    bitSel = SEL_NONE;
    endcase
  endfunction

  logic parity;
  logic [7:0] statusFull;

  assign parity     = ^mainArith_r;
  assign statusFull = {status_r, parity};

  function automatic logic [7:0] readByte(input crf_sel_t s);
    case (s)
      SEL_STACK:  readByte = stackTop_r;
      SEL_PLOW:   readByte = pointer_r[ptrSel_r][7:0];
      SEL_PHIGH:  readByte = pointer_r[ptrSel_r][15:8];
      SEL_STATUS: readByte = statusFull;
      SEL_MAIN:   readByte = mainArith_r;
      SEL_SECOND: readByte = second_r;
      SEL_AUX:    readByte = {7'h00, ptrSel_r};
      default:    readByte = ZERO_BYTE;
    endcase
  endfunction

  // ************************************************************
  // APB decode
  // ************************************************************
  crf_sel_t   busSel;
  logic       busWr;
  logic [7:0] wrByte;

  assign busSel  = regSel(paddr[ADDR_W-1:2]);
  assign pready  = psel & penable;
  assign pslverr = psel & penable & (busSel == SEL_NONE);
  assign busWr   = psel & penable & pwrite & (busSel != SEL_NONE);
  assign wrByte  = pwdata[7:0];

  // Read data is taken in the setup cycle so that it comes from a flop
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= {24'h00_0000, readByte(busSel)};
    end
  end
  assign prdata = prdata_r;

  // ************************************************************
  // Single-bit access
  // ************************************************************
  crf_sel_t   bitTarget;
  logic       bitWr;
  logic [7:0] bitByte;

  assign bitTarget = bitSel(bitAddr);
  assign bitByte   = readByte(bitTarget);
  assign bitWr     = bitValid & bitWrite & (bitTarget != SEL_NONE);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bitReadData_r <= 1'b0;
    end else if (bitValid && !bitWrite) begin
      bitReadData_r <= bitByte[bitAddr[2:0]];
    end
  end
  assign bitReadData = bitReadData_r;

  // ************************************************************
  // Arithmetic unit
  // ************************************************************
  logic       aluGo;
  logic [7:0] aluFirst;
  logic [7:0] resA;
  logic [7:0] resB;
  logic       wrA;
  logic       wrB;
  logic       carryOut;
  logic       halfOut;
  logic       rangeOut;
  logic       updCarry;
  logic       updHalf;
  logic       updRange;

  // Compare takes its first operand from the datapath, not the main register
  assign aluGo    = opStart;
  assign aluFirst = (opCode == OP_CJNE) ? opFirst : mainArith_r;

  crf_alu u_alu (
    .opCode   (aluGo ? opCode : OP_NONE),
    .firstIn  (aluFirst),
    .secondIn ((opCode == OP_MUL || opCode == OP_DIV) ? second_r : opSecond),
    .carryIn  (status_r[STAT_CARRY]),
    .halfIn   (status_r[STAT_HALF]),
    .resA     (resA),
    .resB     (resB),
    .wrA      (wrA),
    .wrB      (wrB),
    .carryOut (carryOut),
    .halfOut  (halfOut),
    .rangeOut (rangeOut),
    .updCarry (updCarry),
    .updHalf  (updHalf),
    .updRange (updRange)
  );

  // ************************************************************
  // Main arithmetic and second operand registers
  // ************************************************************
  // Datapath results win over a bus write in the same cycle
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mainArith_r <= RST_BYTE;
    end else if (wrA) begin
      mainArith_r <= resA;
    end else if (bitWr && bitTarget == SEL_MAIN) begin
      mainArith_r[bitAddr[2:0]] <= bitValue;
    end else if (busWr && busSel == SEL_MAIN) begin
      mainArith_r <= wrByte;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      second_r <= RST_BYTE;
    end else if (wrB) begin
      second_r <= resB;
    end else if (bitWr && bitTarget == SEL_SECOND) begin
      second_r[bitAddr[2:0]] <= bitValue;
    end else if (busWr && busSel == SEL_SECOND) begin
      second_r <= wrByte;
    end
  end

  // ************************************************************
  // Status word
  // ************************************************************
  // Parity has no storage, so no write path can reach it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= RST_BYTE[7:1];
    end else begin
      if (bitWr && bitTarget == SEL_STATUS && bitAddr[2:0] != 3'(STAT_PARITY)) begin
        status_r[bitAddr[2:0]] <= bitValue;
      end else if (busWr && busSel == SEL_STATUS) begin
        status_r <= wrByte[7:1];
      end
      if (updCarry) begin
        status_r[STAT_CARRY] <= carryOut;
      end
      if (updHalf) begin
        status_r[STAT_HALF] <= halfOut;
      end
      if (updRange) begin
        status_r[STAT_RANGE] <= rangeOut;
      end
    end
  end

  // Working register bank starts at bank number times eight
  assign bankBase   = {3'b000, status_r[STAT_BANK_HI], status_r[STAT_BANK_LO], 3'b000};
  assign parityFlag = parity;

  // ************************************************************
  // Stack top index
  // ************************************************************
  logic [7:0] stackNext;
  logic       doPush;
  logic       doPop;

  assign doPush    = opStart & (opCode == OP_PUSH);
  assign doPop     = opStart & (opCode == OP_POP);
  assign stackNext = stackTop_r + 8'h01;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stackTop_r <= RST_STACK_TOP;
    end else if (doPush) begin
      stackTop_r <= stackNext;
    end else if (doPop) begin
      stackTop_r <= stackTop_r - 8'h01;
    end else if (busWr && busSel == SEL_STACK) begin
      stackTop_r <= wrByte;
    end
  end

  // The write strobe carries the already incremented index
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stackWrite_r <= 1'b0;
      stackRead_r  <= 1'b0;
      stackAddr_r  <= RST_BYTE;
      stackData_r  <= RST_BYTE;
    end else begin
      stackWrite_r <= doPush;
      stackRead_r  <= doPop;
      if (doPush) begin
        stackAddr_r <= stackNext;
        stackData_r <= pushData;
      end else if (doPop) begin
        stackAddr_r <= stackTop_r;
      end
    end
  end

  assign stackWrite = stackWrite_r;
  assign stackRead  = stackRead_r;
  assign stackAddr  = stackAddr_r;
  assign stackData  = stackData_r;

  // ************************************************************
  // Data pointers and pointer select
  // ************************************************************
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ptrSel_r <= 1'b0;
    end else if (busWr && busSel == SEL_AUX) begin
      ptrSel_r <= wrByte[AUX_PTR_SEL];
    end
  end

  // Byte accesses and increments only touch the selected pointer
  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_ptr
      logic active;
      assign active = (ptrSel_r == 1'(gp));
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          pointer_r[gp] <= RST_POINTER;
        end else if (active) begin
          if (opStart && opCode == OP_INCDP) begin
            pointer_r[gp] <= pointer_r[gp] + 16'h0001;
          end else if (busWr && busSel == SEL_PLOW) begin
            pointer_r[gp][7:0] <= wrByte;
          end else if (busWr && busSel == SEL_PHIGH) begin
            pointer_r[gp][15:8] <= wrByte;
          end
        end
      end
    end
  endgenerate

  assign activePointer = pointer_r[ptrSel_r];
  assign pointerSelect = ptrSel_r;

  // ************************************************************
  // Register views
  // ************************************************************
  assign mainArith     = mainArith_r;
  assign secondOperand = second_r;

endmodule

// ---- bench/crf_core_regs_sva.sv ----
// Checker: port-level properties of the core register block
`timescale 1ns/1ps
module crf_core_regs_sva (
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic        opStart,
  input crf_pkg::crf_op_t opCode,
  input wire logic [7:0]  opSecond,
  input wire logic [7:0]  pushData,
  input wire logic        stackWrite,
  input wire logic [7:0]  stackData,
  input wire logic [7:0]  mainArith,
  input wire logic [7:0]  secondOperand,
  input wire logic [7:0]  bankBase,
  input wire logic        parityFlag,
  input wire logic        pslverr
);
  import crf_pkg::*;
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_parity_track: assert property (parityFlag == ^mainArith)
    else $error("parity differs from main register");
  a_push_data: assert property (opStart && opCode == OP_PUSH |=> stackWrite
    && stackData == $past(pushData)) else $error("push strobe or data wrong");
  a_write_cause: assert property (stackWrite |-> $past(opStart)
    && $past(opCode) == OP_PUSH) else $error("stack write without push");
  a_bank_base: assert property (bankBase[2:0] == 3'h0 && bankBase[7:5] == 3'h0)
    else $error("bank base not a bank start");
  a_mul_pair: assert property (opStart && opCode == OP_MUL |=> {secondOperand, mainArith}
    == 16'($past(mainArith)) * 16'($past(secondOperand))) else $error("product wrong");
  a_div_zero: assert property (opStart && opCode == OP_DIV && secondOperand == 8'h00
    |=> $stable(mainArith) && $stable(secondOperand)) else $error("divide by zero changed");
  a_div_result: assert property (opStart && opCode == OP_DIV && secondOperand != 8'h00
    |=> mainArith == $past(mainArith) / $past(secondOperand)
    && secondOperand == $past(mainArith) % $past(secondOperand)) else $error("quotient wrong");
  a_add_result: assert property (opStart && opCode == OP_ADD
    |=> mainArith == 8'($past(mainArith) + $past(opSecond))) else $error("sum wrong");
  c_push: cover property (stackWrite);
  c_mul: cover property (opStart && opCode == OP_MUL);
  c_unmapped: cover property (pslverr);
endmodule

bind crf_core_regs crf_core_regs_sva chk (.sys_clk, .arst_n, .opStart, .opCode, .opSecond,
  .pushData, .stackWrite, .stackData, .mainArith, .secondOperand, .bankBase, .parityFlag,
  .pslverr);

// ---- bench/tb_crf_core_regs.sv ----
// Testbench: register bus, operation and bit ports of the core registers
`timescale 1ns/1ps
module tb_crf_core_regs;
  import crf_pkg::*;
  // ************************************************************
  // Signals and map
  // ************************************************************
  logic        sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, errSeen;
  logic        opStart, stackWrite, stackRead, bitValid, bitWrite, bitValue;
  logic        bitReadData, pointerSelect, parityFlag;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata;
  crf_op_t     opCode;
  logic [7:0]  opFirst, opSecond, pushData, stackAddr, stackData, bitAddr;
  logic [7:0]  mainArith, secondOperand, bankBase;
  logic [15:0] activePointer;
  int          fail_count, samples_checked;
  localparam logic [9:0] A_SP = {IDX_STACK_TOP, 2'b00};
  localparam logic [9:0] A_PL = {IDX_PTR_LOW, 2'b00};
  localparam logic [9:0] A_PH = {IDX_PTR_HIGH, 2'b00};
  localparam logic [9:0] A_AUX = {IDX_AUX_ONE, 2'b00};
  localparam logic [9:0] A_PSW = {IDX_STATUS, 2'b00};
  localparam logic [9:0] A_ACC = {IDX_MAIN, 2'b00};
  localparam logic [9:0] A_B = {IDX_SECOND, 2'b00};

  crf_core_regs uut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .opStart, .opCode, .opFirst, .opSecond, .pushData,
    .stackWrite, .stackRead, .stackAddr, .stackData, .bitValid, .bitWrite, .bitAddr,
    .bitValue, .bitReadData, .mainArith, .secondOperand, .activePointer, .pointerSelect,
    .bankBase, .parityFlag);

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ************************************************************
  // Drivers and compare
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Only the watchdog ends a hung access
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [31:0] x;
    apb(1'b1, a, {24'h0, d}, x);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [7:0] e);
    logic [31:0] x;
    apb(1'b0, a, 32'h0, x);
    chk(x, {24'h0, e});
  endtask
  task automatic op(input crf_op_t c, input logic [7:0] f, input logic [7:0] s);
    @(posedge sys_clk);
    opStart <= 1'b1;
    opCode <= c;
    opFirst <= f;
    pushData <= f;
    opSecond <= s;
    @(posedge sys_clk);
    opStart <= 1'b0;
    #1;
  endtask
  task automatic bop(input logic [7:0] a, input logic w, input logic v);
    @(posedge sys_clk);
    bitValid <= 1'b1;
    bitWrite <= w;
    bitAddr <= a;
    bitValue <= v;
    @(posedge sys_clk);
    bitValid <= 1'b0;
    #1;
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    rdc(A_SP, 8'h07);
    rdc(A_PL, 8'h00);
    rdc(A_PH, 8'h00);
    rdc(A_PSW, 8'h00);
    rdc(A_ACC, 8'h00);
    rdc(A_B, 8'h00);
    rdc(10'h3FC, 8'h00);
    chk(32'(errSeen), 32'h1);
    op(OP_PUSH, 8'h5A, 8'h00);
    chk(32'({stackWrite, stackAddr, stackData}), 32'h1085A);
    rdc(A_SP, 8'h08);
    $display("t_reset done");
  endtask
  task automatic t_status();
    wr(A_ACC, 8'h07);
    chk(32'(parityFlag), 32'h1);
    wr(A_ACC, 8'h03);
    wr(A_PSW, 8'hFF);
    rdc(A_PSW, 8'hFE);
    for (int b = 0; b < 4; b++) begin
      wr(A_PSW, 8'(b << 3));
      chk(32'(bankBase), 32'(b * 8));
    end
    $display("t_status done");
  endtask
  task automatic t_arith();
    wr(A_PSW, 8'h00);
    wr(A_ACC, 8'h88);
    op(OP_ADD, 8'h00, 8'h88);
    rdc(A_PSW, 8'hC5);
    op(OP_SUBB, 8'h00, 8'h01);
    rdc(A_ACC, 8'h0E);
    rdc(A_PSW, 8'h41);
    wr(A_ACC, 8'h10);
    wr(A_B, 8'h20);
    wr(A_PSW, 8'h80);
    op(OP_MUL, 8'h00, 8'h00);
    rdc(A_B, 8'h02);
    rdc(A_PSW, 8'h04);
    wr(A_ACC, 8'h64);
    wr(A_B, 8'h00);
    wr(A_PSW, 8'h80);
    op(OP_DIV, 8'h00, 8'h00);
    rdc(A_PSW, 8'h05);
    wr(A_B, 8'h07);
    op(OP_DIV, 8'h00, 8'h00);
    chk(32'(secondOperand), 32'h02);
    rdc(A_ACC, 8'h0E);
    rdc(A_PSW, 8'h01);
    wr(A_PSW, 8'h00);
    wr(A_ACC, 8'h9A);
    op(OP_DA, 8'h00, 8'h00);
    rdc(A_PSW, 8'h80);
    op(OP_CJNE, 8'h05, 8'h03);
    rdc(A_PSW, 8'h00);
    op(OP_CJNE, 8'h03, 8'h05);
    rdc(A_PSW, 8'h80);
    $display("t_arith done");
  endtask
  task automatic t_bits();
    wr(A_PSW, 8'h00);
    bop(8'hD5, 1'b1, 1'b1);
    rdc(A_PSW, 8'h20);
    bop(8'hE3, 1'b1, 1'b1);
    rdc(A_ACC, 8'h08);
    bop(8'hE3, 1'b0, 1'b0);
    chk(32'(bitReadData), 32'h1);
    wr(A_PL, 8'h34);
    wr(A_PH, 8'h12);
    chk(32'(activePointer), 32'h1234);
    wr(A_AUX, 8'h01);
    chk(32'({pointerSelect, activePointer}), 32'h10000);
    $display("t_bits done");
  endtask
  task automatic t_more();
    op(OP_INCDP, 8'h00, 8'h00);
    chk(32'(activePointer), 32'h0001);
    wr(A_AUX, 8'h00);
    chk(32'({pointerSelect, activePointer}), 32'h01234);
    op(OP_POP, 8'h00, 8'h00);
    chk(32'({stackRead, stackWrite, stackAddr}), 32'h208);
    rdc(A_SP, 8'h07);
    wr(A_PSW, 8'h80);
    wr(A_ACC, 8'h0F);
    op(OP_ADDC, 8'h00, 8'h01);
    chk(32'(mainArith), 32'h11);
    rdc(A_PSW, 8'h40);
    $display("t_more done");
  endtask
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    {arst_n, psel, penable, pwrite, opStart, bitValid, bitWrite, bitValue} = 8'h00;
    {paddr, pwdata, opFirst, opSecond, pushData, bitAddr} = 74'h0;
    opCode = OP_NONE;
    fail_count = 0;
    samples_checked = 0;
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_reset();
    t_status();
    t_arith();
    t_bits();
    t_more();
    end_of_test();
  end
  // Tests take well under 1000 cycles; allow ten times that
  initial begin
    #80000;
    fail_count++;
    end_of_test();
  end
endmodule
